// [hw/icm_timer.sv]
// IR carrier generator, modulation timer and receive capture.
// Assumes a synchronous register port and a synchronous IR input pin.
`timescale 1ns/1ps
module icm_timer #(
  parameter int DIV_W = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input icm_pkg::icm_bus_req_t bus_in,
  output logic [icm_pkg::DATA_W-1:0] rdata_out,
  input wire logic ir_in_pin_in,
  output logic ir_out_pin_out,
  output logic ir_out_pin_oe_out,
  output logic envelope_out_pin_out,
  output logic irq_out
);
  import icm_pkg::*;

  icm_ctrl_t ctrl_q;
  logic [DATA_W-1:0] carrier_period_reg;
  logic [DATA_W-1:0] interval_length_reg;
  logic [DATA_W-1:0] interval_counter;
  logic interval_flag;
  logic counter_overflow_flag;
  logic tx_active;
  logic rx_started;
  logic pin_prev;
  logic car_phase;
  logic [CAR_W-1:0] car_cnt;
  logic [CAR_W-1:0] lat_high;
  logic [CAR_W-1:0] lat_low;
  logic lat_pol;
  logic lat_mod;
  logic ir_input_clock;

  logic tx_run;
  logic rx_run;
  logic tx_start;
  logic car_run;
  logic car_wrap;
  logic iv_clk;
  logic boundary;
  logic qual;
  logic capture;
  logic rx_capture;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_car;
  logic wr_len;
  logic [CAR_W-1:0] src_high;
  logic [CAR_W-1:0] src_low;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    case (sel)
      EDGE_FALL: edge_hit = prev & ~cur;
      EDGE_RISE: edge_hit = ~prev & cur;
      EDGE_BOTH: edge_hit = prev ^ cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  always_comb begin
    tx_run = ctrl_q.timer_enable_bit & ctrl_q.direction_bit;
    rx_run = ctrl_q.timer_enable_bit & ~ctrl_q.direction_bit;
    tx_start = tx_run & ~tx_active;
    car_run = tx_active | rx_run;
    // One carrier cycle ends as the low phase runs out
    car_wrap = ir_input_clock & ~car_phase & (car_cnt == '0);
    iv_clk = ctrl_q.counter_clock_select ? ir_input_clock : car_wrap;
    boundary = tx_active & tx_run & iv_clk & (interval_counter == '0);
    qual = edge_hit(ctrl_q.capture_edge_select, pin_prev, ir_in_pin_in);
    capture = rx_run & qual;
    rx_capture = capture & rx_started;
    // Live carrier register is used outside transmit, latched copy inside
    src_high = tx_active ? lat_high : carrier_period_reg[15:8];
    src_low = tx_active ? lat_low : carrier_period_reg[7:0];
    wr_ctrl = bus_in.wr & (bus_in.addr == OFS_CTRL);
    wr_stat = bus_in.wr & (bus_in.addr == OFS_STATUS);
    wr_car = bus_in.wr & (bus_in.addr == OFS_CARRIER);
    wr_len = bus_in.wr & (bus_in.addr == OFS_LENGTH);
  end

  icm_clkdiv #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(ctrl_q.timer_enable_bit),
    .div_in(ctrl_q.input_clock_divider),
    .tick_out(ir_input_clock)
  );

  // Control; a capture overrides a same-cycle software write of the data bit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= bus_in.wdata;
      end
      if (rx_capture) begin
        ctrl_q.modulation_bit <= ir_in_pin_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carrier_period_reg <= CARRIER_RST;
    end else if (wr_car) begin
      carrier_period_reg <= bus_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interval_length_reg <= LENGTH_RST;
    end else if (rx_capture) begin
      interval_length_reg <= interval_counter;
    end else if (wr_len) begin
      interval_length_reg <= bus_in.wdata;
    end
  end

  // Per-interval sampling lets duty and frequency change between intervals
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lat_high <= '0;
      lat_low <= '0;
      lat_pol <= 1'b0;
      lat_mod <= 1'b0;
      envelope_out_pin_out <= 1'b0;
    end else if (tx_start || boundary) begin
      lat_high <= carrier_period_reg[15:8];
      lat_low <= carrier_period_reg[7:0];
      lat_pol <= ctrl_q.output_polarity_bit;
      lat_mod <= ctrl_q.modulation_bit;
      envelope_out_pin_out <= ctrl_q.modulation_bit ^ ctrl_q.output_polarity_bit;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_active <= 1'b0;
    end else if (!tx_run) begin
      tx_active <= 1'b0;
    end else if (tx_start) begin
      tx_active <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_started <= 1'b0;
    end else if (!rx_run) begin
      rx_started <= 1'b0;
    end else if (capture) begin
      rx_started <= 1'b1;
    end
  end

  // Carrier restarts high at every interval so a new period takes effect at once
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      car_phase <= 1'b0;
      car_cnt <= '0;
    end else if (tx_start || boundary) begin
      car_phase <= 1'b1;
      car_cnt <= carrier_period_reg[15:8];
    end else if (!car_run) begin
      car_phase <= 1'b0;
      car_cnt <= '0;
    end else if (ir_input_clock) begin
      if (car_cnt == '0) begin
        car_phase <= ~car_phase;
        car_cnt <= car_phase ? src_low : src_high;
      end else begin
        car_cnt <= car_cnt - CAR_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interval_counter <= '0;
    end else if (!ctrl_q.timer_enable_bit) begin
      interval_counter <= '0;
    end else if (tx_run) begin
      if (tx_start) begin
        interval_counter <= interval_length_reg;
      end else if (iv_clk) begin
        if (interval_counter == '0) begin
          interval_counter <= interval_length_reg;
        end else begin
          interval_counter <= interval_counter - DATA_W'(1);
        end
      end
    end else if (capture && (!rx_started || ctrl_q.capture_reload_enable)) begin
      interval_counter <= '0;
    end else if (rx_started && iv_clk) begin
      interval_counter <= interval_counter + DATA_W'(1);
    end
  end

  // Hardware set wins over a same-cycle write-one clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interval_flag <= 1'b0;
    end else if (boundary || rx_capture) begin
      interval_flag <= 1'b1;
    end else if (wr_stat && bus_in.wdata[ST_IFLAG]) begin
      interval_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counter_overflow_flag <= 1'b0;
    end else if (rx_started && rx_run && iv_clk && !capture && interval_counter == CNT_MAX) begin
      counter_overflow_flag <= 1'b1;
    end else if (wr_stat && bus_in.wdata[ST_OVF]) begin
      counter_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= ir_in_pin_in;
    end
  end

  // Pin drive; output lags the carrier state by one clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ir_out_pin_out <= 1'b0;
      ir_out_pin_oe_out <= 1'b0;
    end else if (!ctrl_q.timer_enable_bit) begin
      ir_out_pin_out <= ctrl_q.manual_out_level;
      ir_out_pin_oe_out <= ctrl_q.manual_out_drive;
    end else begin
      ir_out_pin_oe_out <= 1'b1;
      if (!tx_active) begin
        ir_out_pin_out <= ctrl_q.output_polarity_bit;
      end else if (ctrl_q.envelope_select == ENV_RAW) begin
        ir_out_pin_out <= car_phase ^ lat_pol;
      end else if (lat_mod) begin
        ir_out_pin_out <= car_phase ^ lat_pol;
      end else begin
        ir_out_pin_out <= lat_pol;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (interval_flag & ctrl_q.interval_irq_enable) |
                 (counter_overflow_flag & ctrl_q.ovf_irq_enable);
    end
  end

  // Unmapped offsets and idle cycles read as zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        OFS_CTRL: rdata_out <= ctrl_q;
        OFS_STATUS: rdata_out <= {11'h000, rx_started, tx_active, ir_in_pin_in,
                                  counter_overflow_flag, interval_flag};
        OFS_CARRIER: rdata_out <= carrier_period_reg;
        OFS_LENGTH: rdata_out <= interval_length_reg;
        OFS_COUNTER: rdata_out <= interval_counter;
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_MANUAL: assert property (!ctrl_q.timer_enable_bit |=>
    ir_out_pin_oe_out == $past(ctrl_q.manual_out_drive) &&
    ir_out_pin_out == $past(ctrl_q.manual_out_level))
    else $error("manual pin control not followed");
  AST_IDLE: assert property (ctrl_q.timer_enable_bit && !tx_active |=>
    ir_out_pin_oe_out && ir_out_pin_out == $past(ctrl_q.output_polarity_bit))
    else $error("idle level wrong");
  AST_START: assert property (tx_start |=>
    tx_active && interval_counter == $past(interval_length_reg))
    else $error("transmit start did not load counter");
  AST_DOWN: assert property (tx_active && tx_run && iv_clk &&
    interval_counter != 16'h0000 |=> interval_counter == $past(interval_counter) - 16'h0001)
    else $error("interval counter did not count down");
  AST_RELOAD: assert property (boundary |=>
    interval_counter == $past(interval_length_reg) && interval_flag && car_phase)
    else $error("interval boundary reload missing");
  AST_ENV: assert property (boundary |=>
    envelope_out_pin_out == ($past(ctrl_q.modulation_bit) ^ $past(ctrl_q.output_polarity_bit)))
    else $error("envelope pin wrong at boundary");
  AST_CARHOLD: assert property (car_run && ir_input_clock && car_cnt != 8'h00 &&
    !tx_start && !boundary |=> car_phase == $past(car_phase) &&
    car_cnt == $past(car_cnt) - 8'h01)
    else $error("carrier phase ended early");
  AST_RXFIRST: assert property (capture && !rx_started |=>
    rx_started && interval_counter == 16'h0000)
    else $error("first capture did not start counter at zero");
  AST_CAPTURE: assert property (rx_capture |=>
    ctrl_q.modulation_bit == $past(ir_in_pin_in) &&
    interval_length_reg == $past(interval_counter) && interval_flag)
    else $error("capture did not store level and count");
  AST_OVF: assert property (rx_started && rx_run && iv_clk && !capture &&
    interval_counter == 16'hffff |=> counter_overflow_flag && interval_counter == 16'h0000)
    else $error("overflow flag missing on wrap");
  AST_STOP: assert property (!ctrl_q.timer_enable_bit |=>
    !tx_active && !rx_started && interval_counter == 16'h0000)
    else $error("disable did not stop timer");
endmodule : icm_timer

// [pkg/icm_pkg.sv]
// Shared constants, register map, control and bus types for the IR carrier timer.
// Assumes a 16-bit register port with byte-free word addressing by offset.
package icm_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int CAR_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CARRIER = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LENGTH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h10;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CARRIER_RST = 16'h0000;
  localparam logic [DATA_W-1:0] LENGTH_RST = 16'h0000;

  // Status bit positions
  localparam int ST_IFLAG = 0;
  localparam int ST_OVF = 1;
  localparam int ST_PIN = 2;
  localparam int ST_TX = 3;
  localparam int ST_RX = 4;

  // Envelope select codes
  localparam logic [1:0] ENV_MOD = 2'h1;
  localparam logic [1:0] ENV_RAW = 2'h2;

  // Capture edge select codes; zero disables capture
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [DATA_W-1:0] CNT_MAX = 16'hffff;

  // Control register, bit 0 first from the bottom
  typedef struct packed {
    logic ovf_irq_enable;
    logic interval_irq_enable;
    logic capture_reload_enable;
    logic [1:0] capture_edge_select;
    logic [1:0] envelope_select;
    logic [1:0] input_clock_divider;
    logic manual_out_drive;
    logic manual_out_level;
    logic modulation_bit;
    logic output_polarity_bit;
    logic counter_clock_select;
    logic direction_bit;
    logic timer_enable_bit;
  } icm_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } icm_bus_req_t;
endpackage : icm_pkg

// [hw/icm_clkdiv.sv]
// Input clock tick generator: one-cycle tick every 2^div system clocks.
// Assumes run_in is low whenever the timer is disabled.
`timescale 1ns/1ps
module icm_clkdiv #(
  parameter int DIV_W = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [DIV_W-1:0] div_in,
  output logic tick_out
);
  localparam int CNT_W = (1 << DIV_W) - 1;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] mask;

  always_comb begin
    mask = CNT_W'((1 << div_in) - 1);
  end

  // Counter restarts while stopped so the first tick has a full period
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt <= cnt + CNT_W'(1);
      tick_out <= ((cnt & mask) == mask);
    end
  end
endmodule : icm_clkdiv

// [dv/icm_ir_partner.sv]
// Behavioural IR emitter load and IR detector facing the carrier timer.
// Assumes the bench moves rx_level_in only just after a rising clock edge.
`timescale 1ns/1ps
module icm_ir_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ir_out_pin_in,
  input wire logic ir_out_pin_oe_in,
  input wire logic rx_level_in,
  output logic ir_in_pin_out,
  output logic emit_level_out
);
  logic last;
  // Detector output is registered, as a real receiver settles after an edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ir_in_pin_out <= 1'b0;
      last <= 1'b0;
    end else begin
      ir_in_pin_out <= rx_level_in;
      if (ir_out_pin_oe_in) begin
        last <= ir_out_pin_in;
      end
    end
  end
  // Emitter line has no pull: once released it must not look like the old level
  assign emit_level_out = ir_out_pin_oe_in ? ir_out_pin_in : ~last;
endmodule : icm_ir_partner

// [dv/icm_tb.sv]
// Self-checking bench for the IR carrier timer with its emitter and detector.
// Assumes the register map and control bit layout of the timer package.
`timescale 1ns/1ps
module testbench;
  import icm_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  icm_bus_req_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic ir_pin, ir_oe, env, irq, det, seen;
  logic rx_level = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;
  always #4 clk_in = ~clk_in;
  icm_timer dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata),
    .ir_in_pin_in(det), .ir_out_pin_out(ir_pin), .ir_out_pin_oe_out(ir_oe),
    .envelope_out_pin_out(env), .irq_out(irq));
  icm_ir_partner peer_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ir_out_pin_in(ir_pin),
    .ir_out_pin_oe_in(ir_oe), .rx_level_in(rx_level), .ir_in_pin_out(det),
    .emit_level_out(seen));
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_in);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    bus <= '0;
    #1 v = rdata;
  endtask : rd
  task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(name, e, v);
  endtask : rdchk
  task automatic off();
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_STATUS, 16'h0003);
  endtask : off
  task automatic wait_irq(input logic lvl);
    for (int k = 0; k < 2000 && irq !== lvl; k++) @(negedge clk_in);
  endtask : wait_irq
  task automatic pulse(output int hi, output int lo);
    hi = 0;
    lo = 0;
    // Skip one high stretch: the idle level before the carrier may merge with it
    for (int k = 0; k < 500 && seen !== 1'b1; k++) @(negedge clk_in);
    for (int k = 0; k < 500 && seen !== 1'b0; k++) @(negedge clk_in);
    for (int k = 0; k < 500 && seen !== 1'b1; k++) @(negedge clk_in);
    while (seen === 1'b1 && hi < 500) begin
      hi++;
      @(negedge clk_in);
    end
    while (seen === 1'b0 && lo < 500) begin
      lo++;
      @(negedge clk_in);
    end
  endtask : pulse
  task automatic count_hi(output int n);
    n = 0;
    repeat (40) begin
      @(negedge clk_in);
      n += int'(seen === 1'b1);
    end
  endtask : count_hi
  task automatic t_reset();
    chk("pins_reset", 16'h0000, {13'h0, ir_pin, ir_oe, env});
    rdchk("ctrl", OFS_CTRL, CTRL_RST);
    rdchk("carrier", OFS_CARRIER, CARRIER_RST);
    rdchk("length", OFS_LENGTH, LENGTH_RST);
    wr(8'h14, 16'hffff);
    rdchk("unmapped", 8'h02, 16'h0000);
    rdchk("ctrl_kept", OFS_CTRL, CTRL_RST);
    wr(OFS_CARRIER, 16'h1234);
    rdchk("carrier_rw", OFS_CARRIER, 16'h1234);
  endtask : t_reset
  task automatic t_manual();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, i < 2 ? 16'(16'h0040 | (i << 5)) : 16'(16'h0001 | ((i - 2) << 3)));
      repeat (3) @(negedge clk_in);
      chk("pin_oe", {14'h0, 1'b1, 1'(i)}, {14'h0, ir_oe, ir_pin});
    end
  endtask : t_manual
  task automatic t_carrier();
    int hi, lo;
    for (int pol = 0; pol < 2; pol++) begin
      for (int div = 0; div < 4; div++) begin
        off();
        wr(OFS_CARRIER, 16'h0102);
        wr(OFS_LENGTH, 16'hffff);
        wr(OFS_CTRL, 16'(16'h0013 | (pol << 3) | (div << 7)));
        pulse(hi, lo);
        chk("car_hi", 16'((pol ? 3 : 2) << div), 16'(hi));
        chk("car_lo", 16'((pol ? 2 : 3) << div), 16'(lo));
      end
    end
  endtask : t_carrier
  task automatic t_interval();
    longint t1;
    for (int cf = 0; cf < 2; cf++) begin
      off();
      wr(OFS_CARRIER, 16'h0000);
      wr(OFS_LENGTH, 16'h0007);
      wr(OFS_CTRL, 16'(16'h4013 | (cf << 2)));
      wait_irq(1'b1);
      t1 = $time;
      wr(OFS_STATUS, 16'h0001);
      wait_irq(1'b0);
      wait_irq(1'b1);
      chk("interval", cf ? 16'd8 : 16'd16, 16'(($time - t1) / 8));
    end
  endtask : t_interval
  task automatic t_envelope();
    int hi, lo;
    off();
    wr(OFS_CARRIER, 16'h0000);
    wr(OFS_LENGTH, 16'h0040);
    wr(OFS_CTRL, 16'h4017);
    wait_irq(1'b1);
    chk("env_data1", 16'h0001, {15'h0, env});
    wr(OFS_STATUS, 16'h0001);
    wr(OFS_CTRL, 16'h4007);
    chk("env_latched", 16'h0001, {15'h0, env});
    wait_irq(1'b1);
    chk("env_data0", 16'h0000, {15'h0, env});
    count_hi(hi);
    chk("idle_low", 16'h0000, 16'(hi));
    wr(OFS_STATUS, 16'h0001);
    wr(OFS_CTRL, 16'h440f);
    wait_irq(1'b1);
    chk("env_pol", 16'h0001, {15'h0, env});
    pulse(hi, lo);
    chk("raw_carrier", 16'h0101, {8'(hi), 8'(lo)});
    wr(OFS_STATUS, 16'h0001);
    wr(OFS_CTRL, 16'h420f);
    wait_irq(1'b1);
    count_hi(hi);
    chk("idle_high", 16'd40, 16'(hi));
  endtask : t_envelope
  task automatic t_receive();
    logic [15:0] v;
    int d;
    for (int sel = 0; sel < 4; sel++) begin
      off();
      wr(OFS_LENGTH, 16'h0000);
      wr(OFS_CARRIER, 16'h0000);
      // Fall-only run counts two-tick carrier cycles, the others input clocks
      wr(OFS_CTRL, 16'(16'h0001 | ((sel != 1) << 2) | (sel << 11) | ((sel != 2) << 13)));
      for (int e = 0; e < 4; e++) begin
        repeat (e == 0 ? 5 : 30) @(posedge clk_in);
        rx_level <= ~e[0];
      end
      repeat (10) @(posedge clk_in);
      d = sel[0] ? 30 : 60;
      rd(OFS_LENGTH, v);
      chk("len_cap", 16'(sel != 0), 16'(v >= d - 3 && v <= d + 1));
      rd(OFS_CTRL, v);
      chk("mod_bit", 16'(sel == 2), {15'h0, v[4]});
      rd(OFS_STATUS, v);
      chk("rx_flags", sel != 0 ? 16'h0003 : 16'h0000, {14'h0, v[4], v[0]});
      rd(OFS_COUNTER, v);
      chk("cnt_reload", 16'h0001, 16'(sel == 2 ? v > 60 : v < 25));
    end
  endtask : t_receive
  task automatic t_overflow();
    logic [15:0] v;
    off();
    // Rising edge select, so the single rise below starts the count
    wr(OFS_CTRL, 16'h9005);
    rx_level <= 1'b1;
    repeat (65000) @(posedge clk_in);
    rd(OFS_STATUS, v);
    chk("ovf_early", 16'h0000, {15'h0, v[1]});
    repeat (600) @(posedge clk_in);
    rd(OFS_STATUS, v);
    chk("ovf_set", 16'h0003, {14'h0, irq, v[1]});
  endtask : t_overflow
  task automatic t_disable();
    off();
    wr(OFS_CTRL, 16'h0013);
    repeat (20) @(posedge clk_in);
    wr(OFS_CTRL, 16'h0060);
    repeat (3) @(negedge clk_in);
    chk("manual_back", 16'h0003, {14'h0, ir_oe, ir_pin});
    rdchk("cnt_stop", OFS_COUNTER, 16'h0000);
  endtask : t_disable
  // Longest scenario is the counter wrap, about 66k cycles
  initial begin
    repeat (90000) @(posedge clk_in);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_manual();
    t_carrier();
    t_interval();
    t_envelope();
    t_receive();
    t_disable();
    t_overflow();
    conclude();
  end
endmodule : testbench
